// ---- rtl/alarm_qualify_and_mask.sv ----
// What this block does
// R1 - Channel count code selects 1 to 256
// R2 - Temperature count code selects 1 to 8
// R3 - Flag sets after N consecutive bad samples
// R4 - Enable bits never affect flag setting
// R5 - Over-temperature flag drives pin whenever the pin enable is set
// R6 - Bit 14 gates channel 0 onto pin
// R7 - Bit 13 gates channel 1 onto pin
// R8 - Bit 12 gates channel 2 onto pin
// R9 - Bit 11 gates channel 3 onto pin
// R10 - Bits 10, 9 gate local temperature
// R11 - Bits 8, 7 gate remote one
// R12 - Bits 6, 5 gate remote two
// R13 - Bit 4 gates remote one fault
// R14 - Bit 3 gates remote two fault
// R15 - Hold disabled: flags follow the condition
// R16 - Held flag clears after subside and read
// R17 - Control bits 15, 1, 0 read zero
// R18 - Control register at 4Eh, resets zero
// R19 - Alarm pin is active low
// R20 - In-range sample restarts the count
// R21 - Count fields in config register 1
// R22 - Status read clears flags, reasserted later; here a read clears only flags whose condition is gone, live ones stay set
// R23 - Pin is OR of masked flags, inverted
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module alarm_qualify_and_mask (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [alarm_qualify_pkg::ADDR_W-1:0] paddr,
   input wire logic [alarm_qualify_pkg::DATA_W-1:0] pwdata,
   output logic [alarm_qualify_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sample_strobe,
   input wire logic [alarm_qualify_pkg::SRC_HI:alarm_qualify_pkg::OVER_TEMP_BIT] source_bad,
   output logic alarm_n
);
   import alarm_qualify_pkg::*;

   // Consecutive samples needed for a count code
   // Channel code 0 means one sample, code k above 0 means 2 to the k+1
   // Temperature and fault codes are a plain power of two
   // The result fits the counter width, so 256 is the largest target
   // Kept as a function so both targets share one encoder
   function automatic logic [CNT_W-1:0] needed_samples(input logic is_chan,
                                                       input logic [2:0] code);
      logic [3:0] shift;
      shift = 4'h0;
      if (is_chan) begin
         shift = (code == 3'h0) ? 4'h0 : {1'b0, code} + 4'h1;
      end else begin
         shift = {2'h0, code[1:0]};
      end
      needed_samples = CNT_W'(9'h001 << shift);
   endfunction : needed_samples

   // Software-visible registers and their next values
   logic [15:0] cfg1_q;
   logic [15:0] cfg1_d;
   logic [15:0] alarm_ctrl_q;
   logic [15:0] alarm_ctrl_d;
   logic [15:0] pin_ctrl_q;
   logic [15:0] pin_ctrl_d;

   // Status flags, qualified conditions and this sample's set events
   logic [SRC_HI:OVER_TEMP_BIT] flag_q;
   logic [SRC_HI:OVER_TEMP_BIT] flag_d;
   logic [SRC_HI:OVER_TEMP_BIT] cond_q;
   logic [SRC_HI:OVER_TEMP_BIT] cond_d;
   logic [SRC_HI:OVER_TEMP_BIT] set_event;

   // One run-length counter per counted source; over-temperature has none
   logic [CNT_W-1:0] cnt_q [SRC_HI:SRC_LO];
   logic [CNT_W-1:0] cnt_d [SRC_HI:SRC_LO];

   // Next values of the registered outputs
   logic [DATA_W-1:0] prdata_d;
   logic pready_d;
   logic pslverr_d;
   logic alarm_n_d;

   // Bus decode: word index from the byte address
   // Byte lanes are ignored; each register is one aligned word
   // An unmapped index answers with an error and reads zero
   // Writes to the status word are dropped without an error
   // Status is cleared only by a completed read, never by the setup alone
   wire [9:0] word_index = paddr[ADDR_W-1:2];
   wire hit_cfg1 = (word_index == CFG1_INDEX);
   wire hit_ctrl = (word_index == ALARM_CTRL_INDEX);
   wire hit_status = (word_index == STATUS_INDEX);
   wire hit_pin = (word_index == PIN_CTRL_INDEX);
   wire hit_any = hit_cfg1 | hit_ctrl | hit_status | hit_pin;
   wire setup_phase = psel & ~penable;
   wire access_done = psel & penable & pready;
   wire do_write = access_done & pwrite & hit_any;
   wire status_read = access_done & ~pwrite & hit_status;

   // R21 count fields held in config register 1
   wire [2:0] ch_code = cfg1_q[CH_COUNT_LSB +: CH_COUNT_W];
   wire [2:0] temp_code = {1'b0, cfg1_q[TEMP_COUNT_LSB +: TEMP_COUNT_W]};
   // R1 channel target
   wire [CNT_W-1:0] ch_needed = needed_samples(1'b1, ch_code);
   // R2 temperature target
   wire [CNT_W-1:0] temp_needed = needed_samples(1'b0, temp_code);
   // R15 hold-disable bit chooses following flags
   wire flag_hold_disable = alarm_ctrl_q[HOLD_DISABLE_BIT];
   // Master pin enable; with it low nothing reaches the pin
   wire pin_enable = pin_ctrl_q[PIN_ENABLE_BIT];

   // Per-source pin enables from the alarm control register
   // R6 channel 0 and pair 0+/1-
   wire ain0_pin_enable = alarm_ctrl_q[SRC_HI];
   // R7 channel 1
   wire ain1_pin_enable = alarm_ctrl_q[SRC_HI-1];
   // R8 channel 2 and pair 2+/3-
   wire ain2_pin_enable = alarm_ctrl_q[SRC_HI-2];
   // R9 channel 3
   wire ain3_pin_enable = alarm_ctrl_q[CHAN_LO];
   // R10 on-die sensor low and high
   wire local_temp_low_pin_enable = alarm_ctrl_q[CHAN_LO-1];
   wire local_temp_high_pin_enable = alarm_ctrl_q[CHAN_LO-2];
   // R11 remote diode one low and high
   wire remote1_low_pin_enable = alarm_ctrl_q[CHAN_LO-3];
   wire remote1_high_pin_enable = alarm_ctrl_q[CHAN_LO-4];
   // R12 remote diode two low and high
   wire remote2_low_pin_enable = alarm_ctrl_q[CHAN_LO-5];
   wire remote2_high_pin_enable = alarm_ctrl_q[CHAN_LO-6];
   // R13 remote diode one fault
   wire remote1_fault_pin_enable = alarm_ctrl_q[SRC_LO+1];
   // R14 remote diode two fault
   wire remote2_fault_pin_enable = alarm_ctrl_q[SRC_LO];

   // Status flags by source; bit i of status matches bit i of control for bits 14 to 3
   wire ain0_range_flag = flag_q[SRC_HI];
   wire ain1_range_flag = flag_q[SRC_HI-1];
   wire ain2_range_flag = flag_q[SRC_HI-2];
   wire ain3_range_flag = flag_q[CHAN_LO];
   wire local_temp_low_flag = flag_q[CHAN_LO-1];
   wire local_temp_high_flag = flag_q[CHAN_LO-2];
   wire remote1_low_flag = flag_q[CHAN_LO-3];
   wire remote1_high_flag = flag_q[CHAN_LO-4];
   wire remote2_low_flag = flag_q[CHAN_LO-5];
   wire remote2_high_flag = flag_q[CHAN_LO-6];
   wire remote1_fault_flag = flag_q[SRC_LO+1];
   wire remote2_fault_flag = flag_q[SRC_LO];
   // Over-temperature has no enable of its own
   wire over_temperature_flag = flag_q[OVER_TEMP_BIT];

   // Each flag gated by its own enable; the flag itself is never gated
   wire ain0_drive = ain0_range_flag & ain0_pin_enable;
   wire ain1_drive = ain1_range_flag & ain1_pin_enable;
   wire ain2_drive = ain2_range_flag & ain2_pin_enable;
   wire ain3_drive = ain3_range_flag & ain3_pin_enable;
   wire local_temp_low_drive = local_temp_low_flag & local_temp_low_pin_enable;
   wire local_temp_high_drive = local_temp_high_flag & local_temp_high_pin_enable;
   wire remote1_low_drive = remote1_low_flag & remote1_low_pin_enable;
   wire remote1_high_drive = remote1_high_flag & remote1_high_pin_enable;
   wire remote2_low_drive = remote2_low_flag & remote2_low_pin_enable;
   wire remote2_high_drive = remote2_high_flag & remote2_high_pin_enable;
   wire remote1_fault_drive = remote1_fault_flag & remote1_fault_pin_enable;
   wire remote2_fault_drive = remote2_fault_flag & remote2_fault_pin_enable;

   // Qualification counters, advanced once per conversion sample
   // The compare uses the next count so the flag sets on the Nth strobe
   // Counters saturate, so a long bad run keeps the condition high
   // Fault sources share the temperature target
   // A good sample drops the condition at once; latching is left to the flags
   always_comb begin
      cond_d = cond_q;
      set_event = '0;
      for (int i = SRC_LO; i <= SRC_HI; i++) begin
         cnt_d[i] = cnt_q[i];
         if (sample_strobe) begin
            if (source_bad[i]) begin
               // R3 set after N in a row
               if (cnt_q[i] != CNT_MAX) begin
                  cnt_d[i] = cnt_q[i] + 9'h001;
               end
               if ((cnt_q[i] + 9'h001) >= ((i >= CHAN_LO) ? ch_needed : temp_needed)) begin
                  cond_d[i] = 1'b1;
                  set_event[i] = 1'b1;
               end
            end else begin
               // R20 in-range sample restarts count
               cnt_d[i] = '0;
               cond_d[i] = 1'b0;
            end
         end
      end
      // Over-temperature carries no qualification count
      if (sample_strobe) begin
         cond_d[OVER_TEMP_BIT] = source_bad[OVER_TEMP_BIT];
         set_event[OVER_TEMP_BIT] = source_bad[OVER_TEMP_BIT];
      end
   end

   // Flag update; a set in the read cycle wins over the clear
   // A read only clears flags whose condition is gone; a live one stays
   // So a live flag stays set through the read instead of being cleared and set again at the next conversion
   // Switching to follow mode copies the conditions at once
   always_comb begin
      flag_d = flag_q;
      for (int i = OVER_TEMP_BIT; i <= SRC_HI; i++) begin
         if (flag_hold_disable) begin
            // R15 flags follow the qualified condition
            flag_d[i] = cond_d[i];
         end else begin
            // R16 hold until subsided and read
            // R22 read clears the flag only once its condition is gone
            if (status_read && !cond_d[i]) begin
               flag_d[i] = 1'b0;
            end
            // R4 flags set without regard to enables
            if (set_event[i]) begin
               flag_d[i] = 1'b1;
            end
         end
      end
   end

   // Register writes take effect at the completing access edge
   // Masks keep reserved bits at zero whatever software writes
   // Conversion-rate bits are stored only; nothing here uses them
   always_comb begin
      cfg1_d = cfg1_q;
      alarm_ctrl_d = alarm_ctrl_q;
      pin_ctrl_d = pin_ctrl_q;
      if (do_write && hit_cfg1) begin
         cfg1_d = pwdata[15:0] & CFG1_WMASK;
      end
      if (do_write && hit_ctrl) begin
         // R17 reserved control bits stay zero
         alarm_ctrl_d = pwdata[15:0] & ALARM_CTRL_WMASK;
      end
      if (do_write && hit_pin) begin
         pin_ctrl_d = pwdata[15:0] & PIN_CTRL_WMASK;
      end
   end

   // Read data is latched in the setup cycle, so status shows pre-clear flags
   // A flag set during the access is not lost: it was not cleared
   // Upper half of the word always reads zero
   always_comb begin
      prdata_d = prdata;
      if (setup_phase) begin
         prdata_d = '0;
         if (hit_cfg1) begin
            prdata_d[15:0] = cfg1_q;
         end
         if (hit_ctrl) begin
            prdata_d[15:0] = alarm_ctrl_q;
         end
         if (hit_status) begin
            prdata_d[SRC_HI:OVER_TEMP_BIT] = flag_q;
         end
         if (hit_pin) begin
            prdata_d[15:0] = pin_ctrl_q;
         end
      end
   end

   // No wait state: ready rises in the first access cycle
   assign pready_d = setup_phase;
   assign pslverr_d = setup_phase & ~hit_any;

   // R23 masked OR of flags drives the pin
   // R6 R7 R8 R9 per-channel enables in the mask
   // R10 R11 R12 R13 R14 temperature and fault enables
   // R5 over-temperature bypasses the mask
   // R19 pin is low while an alarm is active
   assign alarm_n_d = ~(pin_enable & (ain0_drive |
                                      ain1_drive |
                                      ain2_drive |
                                      ain3_drive |
                                      local_temp_low_drive |
                                      local_temp_high_drive |
                                      remote1_low_drive |
                                      remote1_high_drive |
                                      remote2_low_drive |
                                      remote2_high_drive |
                                      remote1_fault_drive |
                                      remote2_fault_drive |
                                      over_temperature_flag));

   // Configuration and control registers
   // After reset every source but over-temperature is masked and flags are latched
   // The pin enable resets high so over-temperature is seen at once
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         cfg1_q <= CFG1_RESET;
         // R18 control register resets to zero
         alarm_ctrl_q <= ALARM_CTRL_RESET;
         pin_ctrl_q <= PIN_CTRL_RESET;
      end else begin
         cfg1_q <= cfg1_d;
         alarm_ctrl_q <= alarm_ctrl_d;
         pin_ctrl_q <= pin_ctrl_d;
      end
   end

   // Counters, conditions and flags
   // Reset clears every run so no stale count carries over
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         flag_q <= '0;
         cond_q <= '0;
         for (int i = SRC_LO; i <= SRC_HI; i++) begin
            cnt_q[i] <= '0;
         end
      end else begin
         flag_q <= flag_d;
         cond_q <= cond_d;
         for (int i = SRC_LO; i <= SRC_HI; i++) begin
            cnt_q[i] <= cnt_d[i];
         end
      end
   end

   // Bus answer and pin, all straight from flops
   // The pin lags the flags by one cycle; this keeps it glitch free
   // Reset leaves the pin released, high
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         prdata <= '0;
         pready <= 1'b0;
         pslverr <= 1'b0;
         alarm_n <= 1'b1;
      end else begin
         prdata <= prdata_d;
         pready <= pready_d;
         pslverr <= pslverr_d;
         alarm_n <= alarm_n_d;
      end
   end
endmodule : alarm_qualify_and_mask

`default_nettype wire

// ---- rtl/alarm_qualify_pkg.sv ----
package alarm_qualify_pkg;
   // APB geometry
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   // Register indices; the byte address is four times the index
   localparam logic [9:0] CFG1_INDEX = 10'h04d;
   localparam logic [9:0] ALARM_CTRL_INDEX = 10'h04e;
   localparam logic [9:0] STATUS_INDEX = 10'h04f;
   localparam logic [9:0] PIN_CTRL_INDEX = 10'h060;
   // Reset values
   localparam logic [15:0] CFG1_RESET = 16'h0070;
   localparam logic [15:0] ALARM_CTRL_RESET = 16'h0000;
   localparam logic [15:0] PIN_CTRL_RESET = 16'h0001;
   // Writable bits of each register
   localparam logic [15:0] CFG1_WMASK = 16'h03f8;
   localparam logic [15:0] ALARM_CTRL_WMASK = 16'h7ffc;
   localparam logic [15:0] PIN_CTRL_WMASK = 16'h0001;
   // Configuration register 1 fields
   localparam int CH_COUNT_LSB = 5;
   localparam int CH_COUNT_W = 3;
   localparam int TEMP_COUNT_LSB = 3;
   localparam int TEMP_COUNT_W = 2;
   // Alarm control fields
   localparam int HOLD_DISABLE_BIT = 2;
   // Pin control fields
   localparam int PIN_ENABLE_BIT = 0;
   // Source layout in status and control bits
   localparam int SRC_HI = 14;
   localparam int SRC_LO = 3;
   localparam int CHAN_LO = 11;
   localparam int OVER_TEMP_BIT = 2;
   // Consecutive-sample counter width, holds up to 256
   localparam int CNT_W = 9;
   localparam logic [CNT_W-1:0] CNT_MAX = 9'h100;
endpackage : alarm_qualify_pkg

// ---- tb/alarm_qualify_and_mask_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module alarm_qualify_and_mask_asserts
   import alarm_qualify_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [DATA_W-1:0] pwdata,
   input wire logic [DATA_W-1:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic sample_strobe,
   input wire logic [SRC_HI:OVER_TEMP_BIT] source_bad,
   input wire logic alarm_n
);
   // Decode of the word index seen on the bus
   wire logic [9:0] idx = paddr[11:2];
   wire logic mapped = idx == CFG1_INDEX || idx == ALARM_CTRL_INDEX
      || idx == STATUS_INDEX || idx == PIN_CTRL_INDEX;
   wire logic wr_done = pready && pwrite;
   wire logic rd_done = pready && !pwrite;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   sequence setup_s;
      psel && !penable;
   endsequence
   chk_ready_first: assert property (setup_s |=> pready)
      else $error("pready missing in access cycle");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   chk_unmapped_err: assert property (psel && !penable && !mapped && !pwrite |=> pslverr && prdata == 0)
      else $error("unmapped read not refused");
   chk_mapped_ok: assert property (psel && !penable && mapped |=> !pslverr)
      else $error("mapped access refused");
   chk_ctrl_rsvd: assert property (rd_done && idx == ALARM_CTRL_INDEX |-> prdata[15] == 0 && prdata[1:0] == 0)
      else $error("control reserved bits not zero");
   chk_upper_zero: assert property (pready |-> prdata[31:16] == 0)
      else $error("upper read data not zero");
   // Over-temperature has no count and no mask
   chk_overtemp_pin: assert property (sample_strobe && source_bad[2] |-> ##2 !alarm_n)
      else $error("over-temperature did not pull pin");
   chk_pin_cause: assert property ($fell(alarm_n) |-> $past(sample_strobe, 2)
      || $past(wr_done, 2) || $past(wr_done))
      else $error("alarm pin fell without cause");
endmodule : alarm_qualify_and_mask_asserts
bind alarm_qualify_and_mask alarm_qualify_and_mask_asserts u_chk (.sys_clk, .rst_n, .psel,
   .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sample_strobe,
   .source_bad, .alarm_n);
`default_nettype wire

// ---- tb/sample_source.sv ----
`timescale 1ns/1ps
`default_nettype none
module sample_source (
   input wire logic sys_clk,
   output logic sample_strobe,
   output logic [14:2] source_bad
);
   initial begin
      sample_strobe = 1'b0;
      source_bad = '0;
   end
   // One conversion; stale lines show the inverse so nothing relies on them
   task automatic sample(input logic [14:2] b);
      @(posedge sys_clk);
      sample_strobe <= 1'b1;
      source_bad <= b;
      @(posedge sys_clk);
      sample_strobe <= 1'b0;
      source_bad <= ~b;
   endtask : sample
endmodule : sample_source
`default_nettype wire

// ---- tb/alarm_qualify_and_mask_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module alarm_qualify_and_mask_tb;
   import alarm_qualify_pkg::*;
   localparam logic [11:0] CFG = {CFG1_INDEX, 2'b00};
   localparam logic [11:0] CTL = {ALARM_CTRL_INDEX, 2'b00};
   localparam logic [11:0] STA = {STATUS_INDEX, 2'b00};
   localparam logic [14:2] BAD = 13'h1ffe;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [DATA_W-1:0] pwdata = '0;
   logic [DATA_W-1:0] prdata;
   logic pready;
   logic pslverr;
   logic sample_strobe;
   logic alarm_n;
   logic [14:2] source_bad;
   int num_errors = 0;
   int n_checks = 0;
   always #5 sys_clk = ~sys_clk;
   alarm_qualify_and_mask u_dut (.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .sample_strobe, .source_bad, .alarm_n);
   sample_source u_src (.sys_clk, .sample_strobe, .source_bad);
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic wrap_up();
      if (num_errors == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : wrap_up
   // Setup, access, then hold until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
      int n;
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         num_errors++;
         wrap_up();
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask : wr
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic ee);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, '0, r, e);
      chk("read data", r, exp);
      chk("pslverr", {31'h0, e}, {31'h0, ee});
   endtask : rd_chk
   // Pin is registered, so look one edge later
   task automatic pin_chk(input logic exp);
      @(posedge sys_clk);
      #1;
      chk("alarm_n", {31'h0, alarm_n}, {31'h0, exp});
   endtask : pin_chk
   task automatic t_regs();
      rd_chk(CFG, 32'h70, 1'b0);
      rd_chk(CTL, 32'h0, 1'b0);
      rd_chk({PIN_CTRL_INDEX, 2'b00}, 32'h1, 1'b0);
      wr(CTL, 32'hffffffff);
      rd_chk(CTL, 32'h7ffc, 1'b0);
      rd_chk(12'h000, 32'h0, 1'b1);
   endtask : t_regs
   task automatic t_count();
      wr(CTL, 32'h0);
      wr(CFG, 32'h28);
      u_src.sample(BAD);
      u_src.sample('0);
      u_src.sample(BAD);
      rd_chk(STA, 32'h0, 1'b0);
      u_src.sample(BAD);
      rd_chk(STA, 32'h07f8, 1'b0);
      u_src.sample(BAD);
      u_src.sample(BAD);
      rd_chk(STA, 32'h7ff8, 1'b0);
      pin_chk(1'b1);
      for (int i = 3; i < 15; i++) begin
         wr(CTL, 32'h1 << i);
         pin_chk(1'b0);
      end
      u_src.sample('0);
      pin_chk(1'b0);
      rd_chk(STA, 32'h7ff8, 1'b0);
      pin_chk(1'b1);
      rd_chk(STA, 32'h0, 1'b0);
   endtask : t_count
   task automatic t_follow();
      wr(CTL, 32'h7ffc);
      wr(CFG, 32'h0);
      u_src.sample(BAD);
      pin_chk(1'b0);
      u_src.sample('0);
      pin_chk(1'b1);
   endtask : t_follow
   task automatic t_overtemp();
      wr(CTL, 32'h0);
      u_src.sample(13'h0001);
      pin_chk(1'b0);
      u_src.sample('0);
      rd_chk(STA, 32'h4, 1'b0);
      pin_chk(1'b1);
   endtask : t_overtemp
   initial begin
      repeat (16) @(posedge sys_clk);
      rst_n <= 1'b1;
      t_regs();
      t_count();
      t_follow();
      t_overtemp();
      wrap_up();
   end
endmodule : alarm_qualify_and_mask_tb
`default_nettype wire
